// [rtl/vrdac_pkg.sv]
// Package: constants for the reference and converter control block
package vrdac_pkg;
   // Register indices on the plain register port
   localparam logic [1:0] VRDAC_ADDR_REF_CTRL = 2'h0;
   localparam logic [1:0] VRDAC_ADDR_CONV_A = 2'h1;
   localparam logic [1:0] VRDAC_ADDR_CONV_B = 2'h2;
   localparam logic [1:0] VRDAC_ADDR_PIN_STAT = 2'h3;
   // Reference control field positions
   localparam int VRDAC_REF_EN_BIT = 7;
   localparam int VRDAC_REF_RDY_BIT = 6;
   localparam int VRDAC_BUF_EN_BIT = 5;
   localparam int VRDAC_BUF_SS_BIT = 4;
   // Converter control A field positions
   localparam int VRDAC_CONV_EN_BIT = 7;
   localparam int VRDAC_CONV_RNG_BIT = 6;
   localparam int VRDAC_CONV_OE_BIT = 5;
   localparam int VRDAC_CONV_PSS_BIT = 2;
   // Converter control B code field
   localparam int VRDAC_CODE_W = 5;
   // Writable masks; other bits read zero, except reference control bit 6, which reads the ready flag
   localparam logic [7:0] VRDAC_REF_WMASK = 8'hB0;
   localparam logic [7:0] VRDAC_CONV_A_WMASK = 8'hE4;
   localparam logic [7:0] VRDAC_CONV_B_WMASK = 8'h1F;
   // Reset values
   localparam logic [7:0] VRDAC_RESET_VALUE = 8'h00;
   // Ladder exponents per range
   localparam logic [3:0] VRDAC_EXP_LIMITED = 4'h9;
   localparam logic [3:0] VRDAC_EXP_FULL = 4'h5;
   // Stabilization time and derived cycle count
   localparam int VRDAC_CLK_HZ = 10_000_000;
   localparam int VRDAC_SETTLE_NS = 25_000;
   localparam int VRDAC_SETTLE_CYC_RAW = (VRDAC_SETTLE_NS * (VRDAC_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int VRDAC_SETTLE_CYC = (VRDAC_SETTLE_CYC_RAW < 1) ? 1 : VRDAC_SETTLE_CYC_RAW;
   localparam int VRDAC_CNT_W = 12;
   localparam logic [11:0] VRDAC_CNT_RESET = 12'h000;
   // Settle states
   typedef enum logic [1:0] {VRDAC_ST_OFF, VRDAC_ST_SETTLE, VRDAC_ST_READY} vrdac_settle_t;
endpackage : vrdac_pkg

// [rtl/vrdac_ctrl_reg.sv]
// Leaf: one masked 8-bit control register cleared by device reset
`timescale 1ns/10ps
module vrdac_ctrl_reg
   import vrdac_pkg::*;
#(
   parameter logic [7:0] WMASK = 8'hFF
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Write port
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   // Stored value
   output logic [7:0] o_value
);
   logic [7:0] value_q;
   logic [7:0] value_d;

   // Unimplemented bits are masked so they never store
   assign value_d = i_wr ? (i_wdata & WMASK) : value_q;

   // Only reset and writes change it; sleep wake-up never touches it
   always_ff @(posedge i_clock)
   begin
      if (i_srst)
         value_q <= VRDAC_RESET_VALUE;
      else
         value_q <= value_d;
   end

   assign o_value = value_q;
endmodule : vrdac_ctrl_reg

// [rtl/vrdac_settle.sv]
// Leaf: reference stabilization timer driving the ready flag
`timescale 1ns/10ps
module vrdac_settle
   import vrdac_pkg::*;
#(
   parameter int SETTLE_CYC = VRDAC_SETTLE_CYC
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Reference powered
   input wire logic i_powered,
   // Ready flag
   output logic o_ready
);
   vrdac_settle_t state_q;
   vrdac_settle_t state_d;
   logic [11:0] count_q;
   logic [11:0] count_d;
   logic [11:0] last_count;

   assign last_count = 12'(SETTLE_CYC - 1);

   // Power loss drops to off at once; the count restarts each enable
   always_comb
   begin
      state_d = state_q;
      count_d = count_q;
      case (state_q)
         VRDAC_ST_OFF:
         begin
            count_d = VRDAC_CNT_RESET;
            if (i_powered)
               state_d = VRDAC_ST_SETTLE;
         end
         VRDAC_ST_SETTLE:
         begin
            if (!i_powered)
               state_d = VRDAC_ST_OFF;
            else if (count_q == last_count)
               state_d = VRDAC_ST_READY;
            else
               count_d = count_q + 12'h001;
         end
         VRDAC_ST_READY:
         begin
            if (!i_powered)
               state_d = VRDAC_ST_OFF;
         end
         default:
            state_d = VRDAC_ST_OFF;
      endcase
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         state_q <= VRDAC_ST_OFF;
         count_q <= VRDAC_CNT_RESET;
      end
      else
      begin
         state_q <= state_d;
         count_q <= count_d;
      end
   end

   // Ready only while powered and settled
   assign o_ready = (state_q == VRDAC_ST_READY) && i_powered;
endmodule : vrdac_settle

// [rtl/vrdac_top.sv]
// Top: fixed reference and 5-bit ladder converter control logic
// Notes on behaviour
// - Standard variant powers the reference only while reference_enable, bit 7, is one.
// - High-voltage variant keeps the reference powered whatever reference_enable holds.
// - Reference output pin carries a reference only when software sets buffer controls.
// - buffer_source_select bit 4: zero picks bandgap, one picks converter output.
// - output_buffer_enable bit 5 turns the reference pin buffer on or off.
// - Reference-configured output pin has digital functions overridden and reads zero.
// - Ready flag bit 6 reads zero when off or settling, one after settling.
// - Reference control bits 3 to 0 ignore writes and read zero.
// - Sleep wake-up leaves the reference control register unchanged.
// - Device reset clears reference control, disabling its pin output and, on the standard variant, the reference.
// - The converter runs only while converter_enable is set.
// - converter_source_select zero picks supply rail, one picks external reference pin.
// - Output is source times code over two to n; n nine limited, five full.
// - Each range gives 32 equal levels chosen by the 5-bit code.
// - Unbuffered converter output reaches its pin with output enable set, buffer bits clear.
// - Buffer enable routes the source picked by bit 4 through the buffer and makes the pin the reference pin.
// - Converter pin configured for unbuffered converter output overrides digital functions, reads zero.
// - Sleep wake-up leaves converter control A unchanged.
// - Device reset clears both converter control registers and the converter pin output.
// - Control A: enable bit 7, range 6, pin output 5, source 2; rest zero.
// - Control B holds the 5-bit code in bits 4 to 0; bits 7 to 5 zero.
`timescale 1ns/10ps
module vrdac_top
   import vrdac_pkg::*;
#(
   parameter bit HIGH_VOLTAGE = 1'b0,
   parameter int SETTLE_CYC = VRDAC_SETTLE_CYC
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Register port
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Digital pin inputs from the pads
   input wire logic i_ref_pin_in,
   input wire logic i_conv_pin_in,
   // Reference analog controls
   output logic o_ref_power,
   output logic o_buf_enable,
   output logic o_buf_source_conv,
   // Converter analog controls
   output logic o_conv_enable,
   output logic o_conv_source_ext,
   output logic o_conv_range_full,
   output logic [4:0] o_conv_code,
   output logic [3:0] o_conv_exponent,
   output logic o_conv_pin_drive,
   // Pin overrides and read-back
   output logic o_ref_pin_override,
   output logic o_conv_pin_override,
   output logic o_ref_pin_read,
   output logic o_conv_pin_read
);
   logic [7:0] ref_ctrl;
   logic [7:0] conv_a;
   logic [7:0] conv_b;
   logic wr_ref;
   logic wr_conv_a;
   logic wr_conv_b;
   logic ref_powered;
   logic ref_ready;
   logic ref_en;
   logic buf_en;
   logic buf_ss;
   logic conv_en;
   logic conv_rng;
   logic conv_oe;
   logic conv_pss;
   logic unbuf_drive;
   logic ref_pin_ovr;
   logic conv_pin_ovr;
   logic [7:0] ref_view;
   logic [7:0] pin_view;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic ref_pin_s1_q;
   logic ref_pin_s2_q;
   logic conv_pin_s1_q;
   logic conv_pin_s2_q;
   logic ref_power_q;
   logic buf_enable_q;
   logic buf_source_q;
   logic conv_enable_q;
   logic conv_source_q;
   logic conv_range_q;
   logic [4:0] conv_code_q;
   logic [3:0] conv_exp_q;
   logic conv_drive_q;
   logic ref_ovr_q;
   logic conv_ovr_q;
   logic ref_read_q;
   logic conv_read_q;

   // Address decode shared by write strobes
   function automatic logic hit(input logic [1:0] addr, input logic [1:0] target);
      hit = (addr == target);
   endfunction : hit

   assign wr_ref = i_wr && hit(i_addr, VRDAC_ADDR_REF_CTRL);
   assign wr_conv_a = i_wr && hit(i_addr, VRDAC_ADDR_CONV_A);
   assign wr_conv_b = i_wr && hit(i_addr, VRDAC_ADDR_CONV_B);

   // Control registers; no sleep input exists, so wake-up cannot disturb them
   vrdac_ctrl_reg #(.WMASK(VRDAC_REF_WMASK)) u_ref_ctrl
   (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_wr(wr_ref),
      .i_wdata(i_wdata),
      .o_value(ref_ctrl)
   );

   vrdac_ctrl_reg #(.WMASK(VRDAC_CONV_A_WMASK)) u_conv_a
   (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_wr(wr_conv_a),
      .i_wdata(i_wdata),
      .o_value(conv_a)
   );

   vrdac_ctrl_reg #(.WMASK(VRDAC_CONV_B_WMASK)) u_conv_b
   (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_wr(wr_conv_b),
      .i_wdata(i_wdata),
      .o_value(conv_b)
   );

   // Field extraction
   assign ref_en = ref_ctrl[VRDAC_REF_EN_BIT];
   assign buf_en = ref_ctrl[VRDAC_BUF_EN_BIT];
   assign buf_ss = ref_ctrl[VRDAC_BUF_SS_BIT];
   assign conv_en = conv_a[VRDAC_CONV_EN_BIT];
   assign conv_rng = conv_a[VRDAC_CONV_RNG_BIT];
   assign conv_oe = conv_a[VRDAC_CONV_OE_BIT];
   assign conv_pss = conv_a[VRDAC_CONV_PSS_BIT];

   // High-voltage parts hold the reference on permanently
   assign ref_powered = HIGH_VOLTAGE ? 1'b1 : ref_en;

   // Settle timer; a strap change is not expected after reset
   vrdac_settle #(.SETTLE_CYC(SETTLE_CYC)) u_settle
   (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_powered(ref_powered),
      .o_ready(ref_ready)
   );

   // Pin routing: the buffer owns the shared pin whenever it is enabled
   assign unbuf_drive = conv_oe && !buf_ss && !buf_en;
   assign ref_pin_ovr = buf_en;
   assign conv_pin_ovr = unbuf_drive;

   // Pad inputs pass two flops before any logic reads them
   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         ref_pin_s1_q <= 1'b0;
         ref_pin_s2_q <= 1'b0;
         conv_pin_s1_q <= 1'b0;
         conv_pin_s2_q <= 1'b0;
      end
      else
      begin
         ref_pin_s1_q <= i_ref_pin_in;
         ref_pin_s2_q <= ref_pin_s1_q;
         conv_pin_s1_q <= i_conv_pin_in;
         conv_pin_s2_q <= conv_pin_s1_q;
      end
   end

   // Ready flag is live state; written value at bit 6 is masked away
   assign ref_view = ref_ctrl | ({7'h00, ref_ready} << VRDAC_REF_RDY_BIT);
   assign pin_view = {6'h00, conv_pin_ovr ? 1'b0 : conv_pin_s2_q, ref_pin_ovr ? 1'b0 : ref_pin_s2_q};

   // Read mux; unmapped reads return zero
   always_comb
   begin
      rdata_d = 8'h00;
      if (i_rd)
      begin
         case (i_addr)
            VRDAC_ADDR_REF_CTRL: rdata_d = ref_view;
            VRDAC_ADDR_CONV_A: rdata_d = conv_a;
            VRDAC_ADDR_CONV_B: rdata_d = conv_b;
            VRDAC_ADDR_PIN_STAT: rdata_d = pin_view;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Registered outputs; analog controls lag the register by one cycle
   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         rdata_q <= 8'h00;
         ref_power_q <= 1'b0;
         buf_enable_q <= 1'b0;
         buf_source_q <= 1'b0;
         conv_enable_q <= 1'b0;
         conv_source_q <= 1'b0;
         conv_range_q <= 1'b0;
         conv_code_q <= 5'h00;
         conv_exp_q <= VRDAC_EXP_LIMITED;
         conv_drive_q <= 1'b0;
         ref_ovr_q <= 1'b0;
         conv_ovr_q <= 1'b0;
         ref_read_q <= 1'b0;
         conv_read_q <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         ref_power_q <= ref_powered;
         buf_enable_q <= buf_en;
         buf_source_q <= buf_ss;
         conv_enable_q <= conv_en;
         conv_source_q <= conv_pss;
         conv_range_q <= conv_rng;
         conv_code_q <= conv_en ? conv_b[VRDAC_CODE_W-1:0] : 5'h00;
         conv_exp_q <= conv_rng ? VRDAC_EXP_FULL : VRDAC_EXP_LIMITED;
         conv_drive_q <= unbuf_drive && conv_en;
         ref_ovr_q <= ref_pin_ovr;
         conv_ovr_q <= conv_pin_ovr;
         ref_read_q <= ref_pin_ovr ? 1'b0 : ref_pin_s2_q;
         conv_read_q <= conv_pin_ovr ? 1'b0 : conv_pin_s2_q;
      end
   end

   assign o_rdata = rdata_q;
   assign o_ref_power = ref_power_q;
   assign o_buf_enable = buf_enable_q;
   assign o_buf_source_conv = buf_source_q;
   assign o_conv_enable = conv_enable_q;
   assign o_conv_source_ext = conv_source_q;
   assign o_conv_range_full = conv_range_q;
   assign o_conv_code = conv_code_q;
   assign o_conv_exponent = conv_exp_q;
   assign o_conv_pin_drive = conv_drive_q;
   assign o_ref_pin_override = ref_ovr_q;
   assign o_conv_pin_override = conv_ovr_q;
   assign o_ref_pin_read = ref_read_q;
   assign o_conv_pin_read = conv_read_q;

   // Checks next to the logic
   property p_ref_power;
      @(posedge i_clock) disable iff (i_srst)
      (!HIGH_VOLTAGE && $rose(ref_en)) |=> o_ref_power;
   endproperty
   a_ref_power: assert property (p_ref_power) else $error("reference not powered after enable");

   property p_hv_power;
      @(posedge i_clock) disable iff (i_srst)
      HIGH_VOLTAGE && !$past(i_srst) |-> o_ref_power;
   endproperty
   a_hv_power: assert property (p_hv_power) else $error("high-voltage reference not powered");

   property p_buf_src;
      @(posedge i_clock) disable iff (i_srst)
      wr_ref |=> ##1 (o_buf_source_conv == $past(i_wdata[VRDAC_BUF_SS_BIT], 2));
   endproperty
   a_buf_src: assert property (p_buf_src) else $error("buffer source not following write");

   property p_ref_pin_read;
      @(posedge i_clock) disable iff (i_srst)
      o_ref_pin_override |-> !o_ref_pin_read;
   endproperty
   a_ref_pin_read: assert property (p_ref_pin_read) else $error("overridden reference pin read nonzero");

   property p_ready_off;
      @(posedge i_clock) disable iff (i_srst)
      !ref_powered |=> !ref_view[VRDAC_REF_RDY_BIT];
   endproperty
   a_ready_off: assert property (p_ready_off) else $error("ready while reference off");

   property p_unimpl;
      @(posedge i_clock) disable iff (i_srst)
      (ref_ctrl[3:0] == 4'h0) && (conv_a[4:3] == 2'h0) && (conv_a[1:0] == 2'h0) && (conv_b[7:5] == 3'h0);
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bits not zero");

   property p_reset_clear;
      @(posedge i_clock)
      i_srst |=> (ref_ctrl == 8'h00) && (conv_a == 8'h00) && (conv_b == 8'h00) ##1 !o_conv_pin_drive;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear controls");

   property p_exponent;
      @(posedge i_clock) disable iff (i_srst)
      conv_rng |=> (o_conv_exponent == VRDAC_EXP_FULL);
   endproperty
   a_exponent: assert property (p_exponent) else $error("wrong ladder exponent");

   property p_unbuf;
      @(posedge i_clock) disable iff (i_srst)
      o_conv_pin_drive |-> !o_buf_enable && !o_buf_source_conv && o_conv_enable;
   endproperty
   a_unbuf: assert property (p_unbuf) else $error("unbuffered drive with buffer bits set");

   property p_conv_read;
      @(posedge i_clock) disable iff (i_srst)
      o_conv_pin_override |-> !o_conv_pin_read;
   endproperty
   a_conv_read: assert property (p_conv_read) else $error("overridden converter pin read nonzero");

   property p_conv_off;
      @(posedge i_clock) disable iff (i_srst)
      !conv_en |=> !o_conv_enable && (o_conv_code == 5'h00) && !o_conv_pin_drive;
   endproperty
   a_conv_off: assert property (p_conv_off) else $error("converter active while disabled");

   property p_src_sel;
      @(posedge i_clock) disable iff (i_srst)
      1'b1 |=> (o_conv_source_ext == $past(conv_pss));
   endproperty
   a_src_sel: assert property (p_src_sel) else $error("converter source select not following register");

   property p_ref_buf;
      @(posedge i_clock) disable iff (i_srst)
      buf_en |=> o_buf_enable && o_ref_pin_override && !o_conv_pin_override && !o_conv_pin_drive;
   endproperty
   a_ref_buf: assert property (p_ref_buf) else $error("buffer enable did not take the shared pin");

   property p_ready_settle;
      @(posedge i_clock) disable iff (i_srst)
      $rose(ref_powered) |-> !ref_ready ##1 !ref_ready;
   endproperty
   a_ready_settle: assert property (p_ready_settle) else $error("ready set without settling");
endmodule : vrdac_top

// [testbench/tb_top.sv]
// Self-checking bench for the reference and converter control block
`timescale 1ns/10ps
module tb_top;
   import vrdac_pkg::*;
   // Short settle time keeps the run brief
   localparam int SETTLE = 3;
   // Design inputs, all defined at time zero
   logic i_clock = 1'b0;
   logic i_srst = 1'b1;
   logic [1:0] i_addr = 2'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_ref_pin_in = 1'b0;
   logic i_conv_pin_in = 1'b0;
   // Design outputs
   logic [7:0] o_rdata;
   logic o_ref_power, o_buf_enable, o_buf_source_conv, o_conv_enable, o_conv_source_ext;
   logic o_conv_range_full, o_conv_pin_drive, o_ref_pin_override, o_conv_pin_override;
   logic o_ref_pin_read, o_conv_pin_read, hv_power;
   logic [4:0] o_conv_code;
   logic [3:0] o_conv_exponent;
   logic [19:0] obs;
   // Bench state: shadow registers, pad levels, expected reads
   logic [7:0] sh_ref = 8'h00;
   logic [7:0] sh_a = 8'h00;
   logic [7:0] sh_b = 8'h00;
   logic pin_r = 1'b0;
   logic pin_c = 1'b0;
   logic rd_d = 1'b0;
   logic [7:0] exp_q[$];
   int n_errors = 0;
   int n_checks = 0;

   always #50 i_clock = ~i_clock;

   assign obs = {o_ref_power, o_buf_enable, o_buf_source_conv, o_conv_enable, o_conv_source_ext,
      o_conv_range_full, o_conv_code, o_conv_exponent, o_conv_pin_drive, o_ref_pin_override,
      o_conv_pin_override, o_ref_pin_read, o_conv_pin_read};

   vrdac_top #(.HIGH_VOLTAGE(1'b0), .SETTLE_CYC(SETTLE)) i_dut (.i_clock(i_clock), .i_srst(i_srst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_ref_pin_in(i_ref_pin_in), .i_conv_pin_in(i_conv_pin_in), .o_ref_power(o_ref_power),
      .o_buf_enable(o_buf_enable), .o_buf_source_conv(o_buf_source_conv), .o_conv_enable(o_conv_enable),
      .o_conv_source_ext(o_conv_source_ext), .o_conv_range_full(o_conv_range_full),
      .o_conv_code(o_conv_code), .o_conv_exponent(o_conv_exponent), .o_conv_pin_drive(o_conv_pin_drive),
      .o_ref_pin_override(o_ref_pin_override), .o_conv_pin_override(o_conv_pin_override),
      .o_ref_pin_read(o_ref_pin_read), .o_conv_pin_read(o_conv_pin_read));

   // High-voltage variant shares the inputs; only its power output is watched
   vrdac_top #(.HIGH_VOLTAGE(1'b1), .SETTLE_CYC(SETTLE)) i_dut_hv (.i_clock(i_clock), .i_srst(i_srst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(),
      .i_ref_pin_in(i_ref_pin_in), .i_conv_pin_in(i_conv_pin_in), .o_ref_power(hv_power),
      .o_buf_enable(), .o_buf_source_conv(), .o_conv_enable(), .o_conv_source_ext(),
      .o_conv_range_full(), .o_conv_code(), .o_conv_exponent(), .o_conv_pin_drive(),
      .o_ref_pin_override(), .o_conv_pin_override(), .o_ref_pin_read(), .o_conv_pin_read());

   // Expected output vector from the shadow registers and pad levels
   function automatic logic [19:0] exp_out();
      logic ce, co;
      ce = sh_a[VRDAC_CONV_EN_BIT];
      co = sh_a[VRDAC_CONV_OE_BIT] & ~sh_ref[VRDAC_BUF_SS_BIT] & ~sh_ref[VRDAC_BUF_EN_BIT];
      exp_out = {sh_ref[7], sh_ref[5], sh_ref[4], ce, sh_a[2], sh_a[6], ce ? sh_b[4:0] : 5'h00,
         sh_a[6] ? VRDAC_EXP_FULL : VRDAC_EXP_LIMITED, co & ce, sh_ref[5], co, pin_r & ~sh_ref[5], pin_c & ~co};
   endfunction : exp_out

   // Expected read data; pin status reuses the pin read-back terms of the output vector
   function automatic logic [7:0] exp_reg(input logic [1:0] a, input logic rdy);
      logic [19:0] e;
      e = exp_out();
      case (a)
         VRDAC_ADDR_REF_CTRL: exp_reg = sh_ref | {1'b0, rdy, 6'h00};
         VRDAC_ADDR_CONV_A: exp_reg = sh_a;
         VRDAC_ADDR_CONV_B: exp_reg = sh_b;
         default: exp_reg = {6'h00, e[0], e[1]};
      endcase
   endfunction : exp_reg

   task automatic chk_rd(input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error rdata expected %h seen %h", exp, got);
      end
   endtask : chk_rd

   task automatic chk_out(input string what, input logic [19:0] exp, input logic [19:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_out

   // Register writes also update the shadow copy with the writable masks
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_rd <= 1'b0;
      i_addr <= a;
      i_wdata <= d;
      if (a == VRDAC_ADDR_REF_CTRL) sh_ref = d & VRDAC_REF_WMASK;
      if (a == VRDAC_ADDR_CONV_A) sh_a = d & VRDAC_CONV_A_WMASK;
      if (a == VRDAC_ADDR_CONV_B) sh_b = d & VRDAC_CONV_B_WMASK;
   endtask : wr

   task automatic rd(input logic [1:0] a, input logic rdy);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_wr <= 1'b0;
      i_addr <= a;
      exp_q.push_back(exp_reg(a, rdy));
   endtask : rd

   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge i_clock);
         i_wr <= 1'b0;
         i_rd <= 1'b0;
      end
   endtask : idle

   task automatic rd_all(input logic rdy);
      for (int a = 0; a < 4; a++) rd(a[1:0], rdy);
      idle(2);
   endtask : rd_all

   // Remember which edge took a read strobe
   always @(posedge i_clock) rd_d <= i_rd & ~i_srst;

   // Read data stands only in the cycle after the strobe; look mid-cycle where it is settled
   always @(negedge i_clock)
   begin
      if (rd_d && exp_q.size() > 0) chk_rd(exp_q.pop_front(), o_rdata);
      else if (!i_srst) chk_rd(8'h00, o_rdata);
   end

   task automatic complete_run();
      $display("Checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   // Watchdog: the tests need well under 2000 cycles
   initial
   begin
      #600000;
      n_errors++;
      complete_run();
   end

   // Table of buffer and pin settings: {reference control, control A}
   logic [15:0] pin_tab[4] = '{16'h0000, 16'h00A0, 16'h20A0, 16'h10A0};

   initial
   begin
      void'($urandom(74));
      repeat (4) @(posedge i_clock);
      i_srst <= 1'b0;
      idle(2);
      chk_out("outputs", exp_out(), obs);
      chk_out("hv_power", 20'h00001, {19'h00000, hv_power});
      rd_all(1'b0);
      $display("Test reset_values done");
      // Masks, read-only places and the ready flag while settling and when ready
      wr(VRDAC_ADDR_REF_CTRL, 8'hFF);
      rd(VRDAC_ADDR_REF_CTRL, 1'b0);
      wr(VRDAC_ADDR_CONV_A, 8'hFF);
      wr(VRDAC_ADDR_CONV_B, 8'hFF);
      wr(VRDAC_ADDR_PIN_STAT, 8'hFF);
      idle(SETTLE + 6);
      chk_out("outputs", exp_out(), obs);
      rd_all(1'b1);
      wr(VRDAC_ADDR_REF_CTRL, 8'h30);
      idle(4);
      chk_out("outputs", exp_out(), obs);
      chk_out("hv_power", 20'h00001, {19'h00000, hv_power});
      rd(VRDAC_ADDR_REF_CTRL, 1'b0);
      idle(2);
      $display("Test masks_ready done");
      // Pin overrides for four buffer and output settings
      pin_r = 1'b1;
      pin_c = 1'b1;
      i_ref_pin_in <= 1'b1;
      i_conv_pin_in <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         wr(VRDAC_ADDR_REF_CTRL, pin_tab[k][15:8]);
         wr(VRDAC_ADDR_CONV_A, pin_tab[k][7:0]);
         idle(6);
         chk_out("outputs", exp_out(), obs);
         rd(VRDAC_ADDR_PIN_STAT, 1'b0);
         idle(2);
      end
      $display("Test pin_override done");
      // Random settings of all three registers and both pads
      for (int k = 0; k < 40; k++)
      begin
         wr(VRDAC_ADDR_REF_CTRL, 8'($urandom));
         wr(VRDAC_ADDR_CONV_A, 8'($urandom));
         wr(VRDAC_ADDR_CONV_B, 8'($urandom));
         pin_r = 1'($urandom);
         pin_c = 1'($urandom);
         i_ref_pin_in <= pin_r;
         i_conv_pin_in <= pin_c;
         idle(SETTLE + 6);
         chk_out("outputs", exp_out(), obs);
         rd_all(sh_ref[7]);
      end
      $display("Test random_settings done");
      // Long hold, then a reset in mid-run clears everything
      wr(VRDAC_ADDR_REF_CTRL, 8'hF0);
      wr(VRDAC_ADDR_CONV_A, 8'hE4);
      wr(VRDAC_ADDR_CONV_B, 8'h1F);
      idle(40);
      rd_all(1'b1);
      @(posedge i_clock);
      i_srst <= 1'b1;
      idle(2);
      i_srst <= 1'b0;
      sh_ref = 8'h00;
      sh_a = 8'h00;
      sh_b = 8'h00;
      idle(4);
      chk_out("outputs", exp_out(), obs);
      rd_all(1'b0);
      $display("Test midrun_reset done");
      complete_run();
   end
endmodule : tb_top
